// >>> verification/tb.sv
// Self-checking testbench of the shift, bit manipulation and branch unit
`timescale 1ns/1ps
module tb;
  import sbb_pkg::*;
  logic                  clk_in = 1'b0;
  logic                  rst_n_in;
  logic                  req_valid_in;
  sbb_req_t              req_in;
  logic                  flags_load_in;
  sbb_flags_t            flags_in;
  logic [SBB_ADDR_W-1:0] sp_in;
  logic                  done_out, wr_en_out, pc_load_out, push_out, illegal_out;
  logic [SBB_DATA_W-1:0] result_out;
  sbb_flags_t            flags_out;
  logic [SBB_ADDR_W-1:0] pc_out, push_addr_out, push_data_out, sp_out;
  int                    bad_count = 0;
  int                    tests_run = 0;
  integer                seed = 8;
  sbb_req_t              q;
  sbb_flags_t            mflags;
  logic [31:0]           e_res;
  logic [23:0]           e_pc, e_npc, e_pd, e_sp;
  logic                  e_done, e_wr, e_pcl, e_nt, e_push, e_ill;

  always #2 clk_in = ~clk_in;

  sbb_unit sbb_unit_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .flags_load_in(flags_load_in), .flags_in(flags_in), .sp_in(sp_in),
    .done_out(done_out), .result_out(result_out), .wr_en_out(wr_en_out),
    .flags_out(flags_out), .pc_out(pc_out), .pc_load_out(pc_load_out), .push_out(push_out),
    .push_addr_out(push_addr_out), .push_data_out(push_data_out), .sp_out(sp_out),
    .illegal_out(illegal_out));

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  function automatic logic cond_true(input sbb_cond_t c, input sbb_flags_t f);
    logic        cz, nv, zn;
    logic [15:0] t;
    cz = f.carry | f.zero;
    nv = f.neg ^ f.ovf;
    zn = f.zero | nv;
    t = {zn, !zn, nv, !nv, f.neg, !f.neg, f.ovf, !f.ovf, f.zero, !f.zero, f.carry, !f.carry,
         cz, !cz, 1'b0, 1'b1};
    return t[c];
  endfunction : cond_true

  function automatic logic is_inv(input sbb_op_t o);
    return o inside {SBB_CARRY_AND_INV_BIT, SBB_CARRY_OR_INV_BIT, SBB_CARRY_XOR_INV_BIT,
                     SBB_INV_BIT_LOAD_CARRY, SBB_INV_CARRY_STORE_BIT};
  endfunction : is_inv

  task automatic shf(input sbb_op_t op, input logic [1:0] sz, input logic [31:0] v,
                     input logic c, output logic [31:0] r, output logic co,
                     output logic n, output logic z);
    int          w;
    logic [31:0] m, t;
    logic        hi, lo;
    w = (sz == SBB_SIZE_BYTE) ? 8 : (sz == SBB_SIZE_WORD) ? 16 : 32;
    m = (w == 32) ? 32'hffffffff : ((32'h1 << w) - 32'h1);
    hi = v[w-1];
    lo = v[0];
    t = (v & m) >> 1;
    case (op)
      SBB_ARITH_SHIFT_RIGHT:  t = t | ({31'h0, hi} << (w-1));
      SBB_LOGIC_SHIFT_RIGHT:  t = t;
      SBB_ROTATE_RIGHT:       t = t | ({31'h0, lo} << (w-1));
      SBB_ROTATE_CARRY_RIGHT: t = t | ({31'h0, c} << (w-1));
      SBB_ROTATE_LEFT:        t = (v << 1) | {31'h0, hi};
      SBB_ROTATE_CARRY_LEFT:  t = (v << 1) | {31'h0, c};
      default:                t = v << 1;
    endcase
    co = (op inside {SBB_ARITH_SHIFT_RIGHT, SBB_LOGIC_SHIFT_RIGHT, SBB_ROTATE_RIGHT,
                     SBB_ROTATE_CARRY_RIGHT}) ? lo : hi;
    r = (v & ~m) | (t & m);
    n = r[w-1];
    z = ((r & m) == 32'h0);
  endtask : shf

  task automatic check_out();
    chk("done", 32'(done_out), 32'(e_done));
    chk("flags", 32'(flags_out), 32'(mflags));
    chk("wr_en", 32'(wr_en_out), 32'(e_wr));
    if (e_wr) chk("result", result_out, e_res);
    // A not-taken branch may either hold the PC or load the next address
    if (e_nt) chk("pc_next", 32'(pc_load_out && (pc_out !== e_npc)), 32'h0);
    else chk("pc_load", 32'(pc_load_out), 32'(e_pcl));
    if (e_pcl) chk("pc", 32'(pc_out), 32'(e_pc));
    chk("push", 32'(push_out), 32'(e_push));
    if (e_push) chk("push_addr", 32'(push_addr_out), 32'(e_sp));
    if (e_push) chk("push_data", 32'(push_data_out), 32'(e_pd));
    if (e_push) chk("sp", 32'(sp_out), 32'(e_sp));
    chk("illegal", 32'(illegal_out), 32'(e_ill));
  endtask : check_out

  task automatic step(input logic v, input sbb_req_t r, input logic fl, input sbb_flags_t f,
                      input logic [23:0] sp);
    sbb_flags_t nf, base;
    logic [2:0] bn;
    logic       b;
    @(posedge clk_in);
    #1;
    check_out();
    req_valid_in = v;
    req_in = r;
    flags_load_in = fl;
    flags_in = f;
    sp_in = sp;
    {e_wr, e_pcl, e_nt, e_push, e_ill} = 5'h00;
    e_done = v;
    base = fl ? f : mflags;
    nf = base;
    bn = r.bitno_from_reg ? r.bitno_reg[2:0] : r.bitno_imm;
    b = r.operand[bn];
    e_res = r.operand;
    if (v) begin
      case (r.op)
        SBB_BIT_SET_OP:         {e_res[bn], e_wr} = 2'h3;
        SBB_BIT_CLEAR_OP:       {e_res[bn], e_wr} = 2'h1;
        SBB_BIT_INVERT_OP:      {e_res[bn], e_wr} = {~b, 1'b1};
        SBB_BIT_TEST_OP:        nf.zero = ~b;
        SBB_CARRY_AND_BIT:      nf.carry = nf.carry & b;
        SBB_CARRY_AND_INV_BIT:  nf.carry = nf.carry & ~b;
        SBB_CARRY_OR_BIT:       nf.carry = nf.carry | b;
        SBB_CARRY_OR_INV_BIT:   nf.carry = nf.carry | ~b;
        SBB_CARRY_XOR_BIT:      nf.carry = nf.carry ^ b;
        SBB_CARRY_XOR_INV_BIT:  nf.carry = nf.carry ^ ~b;
        SBB_BIT_LOAD_CARRY:     nf.carry = b;
        SBB_INV_BIT_LOAD_CARRY: nf.carry = ~b;
        SBB_CARRY_STORE_BIT:    {e_res[bn], e_wr} = {nf.carry, 1'b1};
        SBB_INV_CARRY_STORE_BIT: {e_res[bn], e_wr} = {~nf.carry, 1'b1};
        SBB_COND_BRANCH: begin
          e_pcl = cond_true(r.cond, nf);
          e_nt = !e_pcl;
        end
        SBB_RELATIVE_SUBROUTINE_BRANCH, SBB_ABSOLUTE_SUBROUTINE_JUMP: begin
          {e_pcl, e_push} = 2'h3;
          e_sp = sp - SBB_STACK_STEP;
        end
        SBB_NOP:                ;
        default: begin
          e_ill = r.op > SBB_ROTATE_CARRY_RIGHT;
          if (!e_ill) begin
            shf(r.op, r.size, r.operand, nf.carry, e_res, nf.carry, nf.neg, nf.zero);
            nf.ovf = 1'b0;
            e_wr = 1'b1;
          end
        end
      endcase
      if (is_inv(r.op) && r.bitno_from_reg) begin
        {e_ill, e_wr} = 2'h2;
        nf = base;
      end
    end
    mflags = nf;
    e_pc = r.target;
    e_npc = r.next_pc;
    e_pd = r.next_pc;
  endtask : step

  task automatic do_reset(input int n);
    @(posedge clk_in);
    #1;
    rst_n_in = 1'b0;
    req_valid_in = 1'b0;
    flags_load_in = 1'b0;
    repeat (n) @(posedge clk_in);
    #1;
    chk("rst_flags", 32'(flags_out), 32'h0);
    chk("rst_pulses", 32'({done_out, wr_en_out, pc_load_out, push_out}), 32'h0);
    chk("rst_pc_sp", 32'(pc_out) | 32'(sp_out) | result_out, 32'h0);
    rst_n_in = 1'b1;
    mflags = '0;
    {e_done, e_wr, e_pcl, e_nt, e_push, e_ill} = 6'h00;
  endtask : do_reset

  task automatic rnd_run(input int cnt);
    logic v;
    for (int i = 0; i < cnt; i++) begin
      q.op = sbb_op_t'(5'($random(seed)));
      q.size = 2'($unsigned($random(seed)) % 3);
      q.cond = sbb_cond_t'(4'($random(seed)));
      {q.bitno_from_reg, q.bitno_imm} = 4'($random(seed));
      q.operand = $random(seed);
      q.bitno_reg = $random(seed);
      q.next_pc = 24'($random(seed));
      q.target = 24'($random(seed));
      v = ($random(seed) & 7) != 0;
      step(v, q, v && $random(seed) % 2 != 0 && !(is_inv(q.op) && q.bitno_from_reg),
           sbb_flags_t'(4'($random(seed))), 24'($random(seed)));
    end
  endtask : rnd_run

  initial begin
    {rst_n_in, req_valid_in, flags_load_in} = 3'h0;
    req_in = '0;
    flags_in = '0;
    sp_in = '0;
    do_reset(6);
    q = '0;
    q.op = SBB_BIT_SET_OP;
    q.bitno_imm = 3'h3;
    step(1'b1, q, 1'b1, '0, 24'h000000);
    q.op = SBB_LOGIC_SHIFT_LEFT;
    q.operand = 32'h00000080;
    step(1'b1, q, 1'b0, '0, 24'h000000);
    q.op = SBB_RELATIVE_SUBROUTINE_BRANCH;
    q.next_pc = 24'h001234;
    q.target = 24'h00abcd;
    step(1'b1, q, 1'b0, '0, 24'h000100);
    for (int c = 0; c < 16; c++) begin
      for (int f = 0; f < 16; f++) begin
        q.op = SBB_COND_BRANCH;
        q.cond = sbb_cond_t'(4'(c));
        q.target = 24'($random(seed));
        step(1'b1, q, 1'b1, sbb_flags_t'(4'(f)), 24'h000000);
      end
    end
    for (int o = 1; o < 26; o++) begin
      q.op = sbb_op_t'(5'(o));
      q.bitno_from_reg = 1'b1;
      q.bitno_reg = $random(seed);
      q.operand = $random(seed);
      step(1'b1, q, 1'b0, '0, 24'h000004);
    end
    for (int o = 1; o < 9; o++) begin
      for (int s = 0; s < 3; s++) begin
        q.op = sbb_op_t'(5'(o));
        q.size = 2'(s);
        q.operand = 32'h80008081;
        step(1'b1, q, 1'b0, '0, 24'h000000);
      end
    end
    rnd_run(2000);
    do_reset(2);
    rnd_run(200);
    step(1'b0, '0, 1'b0, '0, 24'h000000);
    test_done();
  end

  initial begin
    #50000;
    bad_count++;
    test_done();
  end
endmodule : tb

// >>> verilog/sbb_cond_eval.sv
// Branch condition evaluation from the condition flags
`timescale 1ns/1ps
module sbb_cond_eval
  import sbb_pkg::*;
(
  input  wire sbb_cond_t  cond_in,
  input  wire sbb_flags_t flags_in,
  output logic            taken_out
);

  logic nv;

  always_comb begin
    nv = flags_in.neg ^ flags_in.ovf;
    unique case (cond_in) // RULE19
      SBB_CC_ALWAYS: taken_out = 1'b1;
      SBB_CC_NEVER:  taken_out = 1'b0;
      SBB_CC_HI:     taken_out = ~(flags_in.carry | flags_in.zero);
      SBB_CC_LS:     taken_out = flags_in.carry | flags_in.zero;
      SBB_CC_CC:     taken_out = ~flags_in.carry;
      SBB_CC_CS:     taken_out = flags_in.carry;
      SBB_CC_NE:     taken_out = ~flags_in.zero;
      SBB_CC_EQ:     taken_out = flags_in.zero;
      SBB_CC_VC:     taken_out = ~flags_in.ovf;
      SBB_CC_VS:     taken_out = flags_in.ovf;
      SBB_CC_PL:     taken_out = ~flags_in.neg;
      SBB_CC_MI:     taken_out = flags_in.neg;
      SBB_CC_GE:     taken_out = ~nv;
      SBB_CC_LT:     taken_out = nv;
      SBB_CC_GT:     taken_out = ~(flags_in.zero | nv);
      SBB_CC_LE:     taken_out = flags_in.zero | nv;
    endcase
  end

endmodule : sbb_cond_eval

// >>> verilog/sbb_pkg.sv
// Package with operation codes, flag layout and constants of the shift, bit and branch unit
// Summary of operation
// RULE1 - Arithmetic shift left/right on byte, word or longword register, result written back.
// RULE2 - Logical shift left/right fills vacated bit with zero, result written back.
// RULE3 - Plain rotate: bit leaving one end re-enters the other end.
// RULE4 - Rotate through carry: carry is an extra bit in the rotation loop.
// RULE5 - Bit set forces the selected byte bit to one, others unchanged.
// RULE6 - Bit clear forces the selected byte bit to zero, others unchanged.
// RULE7 - Bit invert complements the selected bit and writes the byte back.
// RULE8 - Bit number comes from 3-bit immediate or low three register bits.
// RULE9 - Bit test leaves operand alone; zero flag gets the inverted bit.
// RULE10 - Carry AND: carry becomes carry AND selected bit or its inverse.
// RULE11 - Carry OR: carry becomes carry OR selected bit or its inverse.
// RULE12 - Carry XOR: carry becomes carry XOR selected bit or its inverse.
// RULE13 - Inverted carry operations take the bit number from the immediate only.
// RULE14 - Bit load copies the selected bit into carry, operand unchanged.
// RULE15 - Inverted bit load puts the inverted selected bit into carry.
// RULE16 - Bit store writes carry into the selected bit, other bits intact.
// RULE17 - Inverted bit store writes inverted carry into the selected bit.
// RULE18 - Conditional branch loads target only when condition true, else next address.
// RULE19 - Sixteen conditions over carry, zero, overflow and negative flags.
// RULE20 - Subroutine branches, relative or absolute, transfer control to the target.
// RULE21 - Shifts and rotates put last bit out in carry, set negative and zero.
// RULE22 - Subroutine branches save the following address on the stack first.
package sbb_pkg;

  localparam int SBB_DATA_W  = 32;
  localparam int SBB_ADDR_W  = 24;
  localparam int SBB_OP_W    = 5;
  localparam int SBB_BITNO_W = 3;

  localparam logic [1:0] SBB_SIZE_BYTE = 2'h0;
  localparam logic [1:0] SBB_SIZE_WORD = 2'h1;
  localparam logic [1:0] SBB_SIZE_LONG = 2'h2;

  // Stack grows down by one longword per saved return address
  localparam logic [SBB_ADDR_W-1:0] SBB_STACK_STEP = 24'h000004;

  typedef enum logic [SBB_OP_W-1:0] {
    SBB_NOP                     = 5'h00,
    SBB_ARITH_SHIFT_LEFT        = 5'h01,
    SBB_ARITH_SHIFT_RIGHT       = 5'h02,
    SBB_LOGIC_SHIFT_LEFT        = 5'h03,
    SBB_LOGIC_SHIFT_RIGHT       = 5'h04,
    SBB_ROTATE_LEFT             = 5'h05,
    SBB_ROTATE_RIGHT            = 5'h06,
    SBB_ROTATE_CARRY_LEFT       = 5'h07,
    SBB_ROTATE_CARRY_RIGHT      = 5'h08,
    SBB_BIT_SET_OP              = 5'h09,
    SBB_BIT_CLEAR_OP            = 5'h0a,
    SBB_BIT_INVERT_OP           = 5'h0b,
    SBB_BIT_TEST_OP             = 5'h0c,
    SBB_CARRY_AND_BIT           = 5'h0d,
    SBB_CARRY_AND_INV_BIT       = 5'h0e,
    SBB_CARRY_OR_BIT            = 5'h0f,
    SBB_CARRY_OR_INV_BIT        = 5'h10,
    SBB_CARRY_XOR_BIT           = 5'h11,
    SBB_CARRY_XOR_INV_BIT       = 5'h12,
    SBB_BIT_LOAD_CARRY          = 5'h13,
    SBB_INV_BIT_LOAD_CARRY      = 5'h14,
    SBB_CARRY_STORE_BIT         = 5'h15,
    SBB_INV_CARRY_STORE_BIT     = 5'h16,
    SBB_COND_BRANCH             = 5'h17,
    SBB_RELATIVE_SUBROUTINE_BRANCH = 5'h18,
    SBB_ABSOLUTE_SUBROUTINE_JUMP   = 5'h19
  } sbb_op_t;

  typedef enum logic [3:0] {
    SBB_CC_ALWAYS = 4'h0, SBB_CC_NEVER = 4'h1, SBB_CC_HI = 4'h2, SBB_CC_LS = 4'h3,
    SBB_CC_CC     = 4'h4, SBB_CC_CS    = 4'h5, SBB_CC_NE = 4'h6, SBB_CC_EQ = 4'h7,
    SBB_CC_VC     = 4'h8, SBB_CC_VS    = 4'h9, SBB_CC_PL = 4'ha, SBB_CC_MI = 4'hb,
    SBB_CC_GE     = 4'hc, SBB_CC_LT    = 4'hd, SBB_CC_GT = 4'he, SBB_CC_LE = 4'hf
  } sbb_cond_t;

  // Condition flags carried as one group
  typedef struct packed {
    logic neg;
    logic zero;
    logic ovf;
    logic carry;
  } sbb_flags_t;

  typedef struct packed {
    sbb_op_t                 op;
    logic [1:0]              size;
    sbb_cond_t               cond;
    logic                    bitno_from_reg;
    logic [SBB_BITNO_W-1:0]  bitno_imm;
    logic [SBB_DATA_W-1:0]   operand;
    logic [SBB_DATA_W-1:0]   bitno_reg;
    logic [SBB_ADDR_W-1:0]   next_pc;
    logic [SBB_ADDR_W-1:0]   target;
  } sbb_req_t;

  localparam logic [SBB_ADDR_W-1:0] SBB_SP_RESET = 24'h000000;
  localparam logic [SBB_ADDR_W-1:0] SBB_PC_RESET = 24'h000000;

endpackage : sbb_pkg

// >>> verilog/sbb_shifter.sv
// Combinational shift and rotate datapath for byte, word and longword operands
`timescale 1ns/1ps
module sbb_shifter
  import sbb_pkg::*;
(
  input  wire sbb_op_t               op_in,
  input  wire logic [1:0]            size_in,
  input  wire logic [SBB_DATA_W-1:0] value_in,
  input  wire logic                  carry_in,
  output logic [SBB_DATA_W-1:0]      result_out,
  output logic                       carry_out,
  output logic                       neg_out,
  output logic                       zero_out
);

  logic [5:0]            msb;
  logic [SBB_DATA_W-1:0] mask;
  logic [SBB_DATA_W-1:0] v;
  logic [SBB_DATA_W-1:0] r;
  logic                  top;
  logic                  low;

  always_comb begin
    unique case (size_in)
      SBB_SIZE_BYTE: begin msb = 6'd7;  mask = 32'h000000ff; end
      SBB_SIZE_WORD: begin msb = 6'd15; mask = 32'h0000ffff; end
      default:       begin msb = 6'd31; mask = 32'hffffffff; end
    endcase
    v   = value_in & mask;
    top = v[msb[4:0]];
    low = v[0];
    r   = v;
    carry_out = carry_in;
    unique case (op_in)
      SBB_ARITH_SHIFT_LEFT, SBB_LOGIC_SHIFT_LEFT: begin // RULE1 RULE2
        r = v << 1;
        carry_out = top; // RULE21
      end
      SBB_ARITH_SHIFT_RIGHT: begin // RULE1
        r = (v >> 1) | ({31'h0, top} << msb);
        carry_out = low; // RULE21
      end
      SBB_LOGIC_SHIFT_RIGHT: begin // RULE2
        r = v >> 1;
        carry_out = low;
      end
      SBB_ROTATE_LEFT: begin // RULE3
        r = (v << 1) | {31'h0, top};
        carry_out = top;
      end
      SBB_ROTATE_RIGHT: begin // RULE3
        r = (v >> 1) | ({31'h0, low} << msb);
        carry_out = low;
      end
      SBB_ROTATE_CARRY_LEFT: begin // RULE4
        r = (v << 1) | {31'h0, carry_in};
        carry_out = top;
      end
      SBB_ROTATE_CARRY_RIGHT: begin // RULE4
        r = (v >> 1) | ({31'h0, carry_in} << msb);
        carry_out = low;
      end
      default: r = v;
    endcase
    // Upper bits outside the operand size are kept from the source register
    result_out = (r & mask) | (value_in & ~mask); // RULE1
    neg_out    = r[msb[4:0]]; // RULE21
    zero_out   = ((r & mask) == 32'h0);
  end

endmodule : sbb_shifter

// >>> verilog/sbb_unit.sv
// Top of the shift, bit manipulation and branch execution unit
`timescale 1ns/1ps
module sbb_unit
  import sbb_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  req_valid_in,
  input  wire sbb_req_t              req_in,
  input  wire logic                  flags_load_in,
  input  wire sbb_flags_t            flags_in,
  input  wire logic [SBB_ADDR_W-1:0] sp_in,
  output logic                       done_out,
  output logic [SBB_DATA_W-1:0]      result_out,
  output logic                       wr_en_out,
  output sbb_flags_t                 flags_out,
  output logic [SBB_ADDR_W-1:0]      pc_out,
  output logic                       pc_load_out,
  output logic                       push_out,
  output logic [SBB_ADDR_W-1:0]      push_addr_out,
  output logic [SBB_ADDR_W-1:0]      push_data_out,
  output logic [SBB_ADDR_W-1:0]      sp_out,
  output logic                       illegal_out
);

  logic                  done_reg, done_next;
  logic [SBB_DATA_W-1:0] result_reg, result_next;
  logic                  wr_en_reg, wr_en_next;
  sbb_flags_t            flags_reg, flags_next;
  logic [SBB_ADDR_W-1:0] pc_reg, pc_next;
  logic                  pc_load_reg, pc_load_next;
  logic                  push_reg, push_next;
  logic [SBB_ADDR_W-1:0] push_addr_reg, push_addr_next;
  logic [SBB_ADDR_W-1:0] push_data_reg, push_data_next;
  logic [SBB_ADDR_W-1:0] sp_reg, sp_next;
  logic                  illegal_reg, illegal_next;

  logic [SBB_DATA_W-1:0] sh_result;
  logic                  sh_carry;
  logic                  sh_neg;
  logic                  sh_zero;
  logic                  cond_true;
  sbb_flags_t            cur_flags;

  logic [SBB_BITNO_W-1:0] bitno;
  logic [7:0]             byte_op;
  logic [7:0]             sel_mask;
  logic                   sel_bit;
  logic                   inv_form;
  logic                   is_shift;

  // Flags written by the rest of the core take effect before this unit reads them
  assign cur_flags = flags_load_in ? flags_in : flags_reg;

  sbb_shifter u_shifter (
    .op_in      (req_in.op),
    .size_in    (req_in.size),
    .value_in   (req_in.operand),
    .carry_in   (cur_flags.carry),
    .result_out (sh_result),
    .carry_out  (sh_carry),
    .neg_out    (sh_neg),
    .zero_out   (sh_zero)
  );

  sbb_cond_eval u_cond (
    .cond_in   (req_in.cond),
    .flags_in  (cur_flags),
    .taken_out (cond_true)
  );

  always_comb begin
    inv_form = (req_in.op == SBB_CARRY_AND_INV_BIT) || (req_in.op == SBB_CARRY_OR_INV_BIT) ||
               (req_in.op == SBB_CARRY_XOR_INV_BIT) || (req_in.op == SBB_INV_BIT_LOAD_CARRY) ||
               (req_in.op == SBB_INV_CARRY_STORE_BIT);
    is_shift = (req_in.op >= SBB_ARITH_SHIFT_LEFT) && (req_in.op <= SBB_ROTATE_CARRY_RIGHT);
    // Inverted forms never take the register bit number; such requests are refused
    bitno    = (req_in.bitno_from_reg && !inv_form) ? req_in.bitno_reg[2:0]
                                                    : req_in.bitno_imm; // RULE8 RULE13
    byte_op  = req_in.operand[7:0];
    sel_mask = 8'h01 << bitno;
    sel_bit  = byte_op[bitno];
  end

  always_comb begin
    done_next      = 1'b0;
    wr_en_next     = 1'b0;
    pc_load_next   = 1'b0;
    push_next      = 1'b0;
    illegal_next   = 1'b0;
    result_next    = result_reg;
    flags_next     = cur_flags;
    pc_next        = pc_reg;
    push_addr_next = push_addr_reg;
    push_data_next = push_data_reg;
    sp_next        = sp_reg;
    if (req_valid_in) begin
      done_next   = 1'b1;
      result_next = req_in.operand;
      if (req_in.bitno_from_reg && inv_form) begin
        illegal_next = 1'b1; // RULE13
      end else if (is_shift) begin
        result_next      = sh_result; // RULE1 RULE2 RULE3 RULE4
        wr_en_next       = 1'b1;
        flags_next.carry = sh_carry; // RULE21
        flags_next.neg   = sh_neg;
        flags_next.zero  = sh_zero;
        flags_next.ovf   = 1'b0;
      end else begin
        unique case (req_in.op)
          SBB_BIT_SET_OP: begin
            result_next = {req_in.operand[31:8], byte_op | sel_mask}; // RULE5
            wr_en_next  = 1'b1;
          end
          SBB_BIT_CLEAR_OP: begin
            result_next = {req_in.operand[31:8], byte_op & ~sel_mask}; // RULE6
            wr_en_next  = 1'b1;
          end
          SBB_BIT_INVERT_OP: begin
            result_next = {req_in.operand[31:8], byte_op ^ sel_mask}; // RULE7
            wr_en_next  = 1'b1;
          end
          SBB_BIT_TEST_OP:       flags_next.zero  = ~sel_bit; // RULE9
          SBB_CARRY_AND_BIT:     flags_next.carry = cur_flags.carry & sel_bit; // RULE10
          SBB_CARRY_AND_INV_BIT: flags_next.carry = cur_flags.carry & ~sel_bit; // RULE10
          SBB_CARRY_OR_BIT:      flags_next.carry = cur_flags.carry | sel_bit; // RULE11
          SBB_CARRY_OR_INV_BIT:  flags_next.carry = cur_flags.carry | ~sel_bit; // RULE11
          SBB_CARRY_XOR_BIT:     flags_next.carry = cur_flags.carry ^ sel_bit; // RULE12
          SBB_CARRY_XOR_INV_BIT: flags_next.carry = cur_flags.carry ^ ~sel_bit; // RULE12
          SBB_BIT_LOAD_CARRY:    flags_next.carry = sel_bit; // RULE14
          SBB_INV_BIT_LOAD_CARRY: flags_next.carry = ~sel_bit; // RULE15
          SBB_CARRY_STORE_BIT: begin
            result_next = {req_in.operand[31:8],
                           cur_flags.carry ? (byte_op | sel_mask)
                                           : (byte_op & ~sel_mask)}; // RULE16
            wr_en_next  = 1'b1;
          end
          SBB_INV_CARRY_STORE_BIT: begin
            result_next = {req_in.operand[31:8],
                           cur_flags.carry ? (byte_op & ~sel_mask)
                                           : (byte_op | sel_mask)}; // RULE17
            wr_en_next  = 1'b1;
          end
          SBB_COND_BRANCH: begin
            pc_next      = cond_true ? req_in.target : req_in.next_pc; // RULE18
            pc_load_next = 1'b1;
          end
          SBB_RELATIVE_SUBROUTINE_BRANCH, SBB_ABSOLUTE_SUBROUTINE_JUMP: begin
            // Return address goes to the pre-decremented stack slot
            sp_next        = sp_in - SBB_STACK_STEP; // RULE22
            push_addr_next = sp_in - SBB_STACK_STEP;
            push_data_next = req_in.next_pc;
            push_next      = 1'b1;
            pc_next        = req_in.target; // RULE20
            pc_load_next   = 1'b1;
          end
          SBB_NOP: done_next = 1'b1;
          default: illegal_next = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      done_reg      <= 1'b0;
      result_reg    <= 32'h0;
      wr_en_reg     <= 1'b0;
      flags_reg     <= 4'h0;
      pc_reg        <= SBB_PC_RESET;
      pc_load_reg   <= 1'b0;
      push_reg      <= 1'b0;
      push_addr_reg <= SBB_SP_RESET;
      push_data_reg <= SBB_PC_RESET;
      sp_reg        <= SBB_SP_RESET;
      illegal_reg   <= 1'b0;
    end else begin
      done_reg      <= done_next;
      result_reg    <= result_next;
      wr_en_reg     <= wr_en_next;
      flags_reg     <= flags_next;
      pc_reg        <= pc_next;
      pc_load_reg   <= pc_load_next;
      push_reg      <= push_next;
      push_addr_reg <= push_addr_next;
      push_data_reg <= push_data_next;
      sp_reg        <= sp_next;
      illegal_reg   <= illegal_next;
    end
  end

  assign done_out      = done_reg;
  assign result_out    = result_reg;
  assign wr_en_out     = wr_en_reg;
  assign flags_out     = flags_reg;
  assign pc_out        = pc_reg;
  assign pc_load_out   = pc_load_reg;
  assign push_out      = push_reg;
  assign push_addr_out = push_addr_reg;
  assign push_data_out = push_data_reg;
  assign sp_out        = sp_reg;
  assign illegal_out   = illegal_reg;

  AST_BIT_SET_RESULT: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE5
    req_valid_in && req_in.op == SBB_BIT_SET_OP && !flags_load_in
    |=> wr_en_out && result_out[7:0] == ($past(req_in.operand[7:0]) | $past(sel_mask)))
    else $error("bit set result wrong");

  AST_BIT_CLEAR_RESULT: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE6
    req_valid_in && req_in.op == SBB_BIT_CLEAR_OP
    |=> result_out[7:0] == ($past(req_in.operand[7:0]) & ~$past(sel_mask)))
    else $error("bit clear result wrong");

  AST_BIT_INVERT_RESULT: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE7
    req_valid_in && req_in.op == SBB_BIT_INVERT_OP
    |=> result_out[7:0] == ($past(req_in.operand[7:0]) ^ $past(sel_mask)))
    else $error("bit invert result wrong");

  AST_BIT_TEST_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE9
    req_valid_in && req_in.op == SBB_BIT_TEST_OP
    |=> flags_out.zero == !$past(sel_bit) && !wr_en_out)
    else $error("bit test zero flag wrong");

  AST_LOAD_CARRY: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE14
    req_valid_in && req_in.op == SBB_BIT_LOAD_CARRY |=> flags_out.carry == $past(sel_bit))
    else $error("bit load carry wrong");

  AST_INV_LOAD_CARRY: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE15
    req_valid_in && req_in.op == SBB_INV_BIT_LOAD_CARRY && !req_in.bitno_from_reg
    |=> flags_out.carry == !$past(sel_bit))
    else $error("inverted bit load carry wrong");

  AST_INV_REG_REFUSED: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE13
    req_valid_in && inv_form && req_in.bitno_from_reg |=> illegal_out && !wr_en_out)
    else $error("inverted form with register bit number accepted");

  AST_BRANCH_PC: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE18
    req_valid_in && req_in.op == SBB_COND_BRANCH
    |=> pc_load_out && pc_out == ($past(cond_true) ? $past(req_in.target)
                                                   : $past(req_in.next_pc)))
    else $error("branch target selection wrong");

  AST_SUB_PUSH: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE22
    req_valid_in && req_in.op == SBB_ABSOLUTE_SUBROUTINE_JUMP
    |=> push_out && push_data_out == $past(req_in.next_pc) && pc_out == $past(req_in.target))
    else $error("subroutine jump did not save return address");

  AST_SHIFT_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE21
    req_valid_in && is_shift && !(req_in.bitno_from_reg && inv_form)
    |=> wr_en_out && flags_out.carry == $past(sh_carry) && flags_out.zero == $past(sh_zero))
    else $error("shift flags wrong");

  AST_CARRY_AND: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE10
    req_valid_in && req_in.op == SBB_CARRY_AND_BIT
    |=> flags_out.carry == ($past(cur_flags.carry) & $past(sel_bit)))
    else $error("carry and bit wrong");

  AST_CARRY_XOR_INV: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE12
    req_valid_in && req_in.op == SBB_CARRY_XOR_INV_BIT && !req_in.bitno_from_reg
    |=> flags_out.carry == ($past(cur_flags.carry) ^ !$past(sel_bit)))
    else $error("carry xor inverted bit wrong");

  AST_CARRY_STORE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE16
    req_valid_in && req_in.op == SBB_CARRY_STORE_BIT |=> wr_en_out &&
    (result_out[7:0] & $past(sel_mask)) == ($past(cur_flags.carry) ? $past(sel_mask) : 8'h00))
    else $error("carry store bit wrong");

  AST_REL_SUB_PC: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE20
    req_valid_in && req_in.op == SBB_RELATIVE_SUBROUTINE_BRANCH
    |=> pc_load_out && push_out && pc_out == $past(req_in.target))
    else $error("relative subroutine branch target wrong");

endmodule : sbb_unit
